/* rtl/bfl_pkg.sv */
`default_nettype none

package bfl_pkg;

  // Register offsets on the two-wire serial port.
  localparam logic [7:0] REG_FAULT_MASK   = 8'h22;
  localparam logic [7:0] REG_FAULT_STATUS = 8'h23;
  localparam logic [7:0] REG_PIN_LIMIT    = 8'h2d;
  localparam logic [7:0] REG_INT_LIMIT    = 8'h2e;
  localparam logic [7:0] REG_FSW_STATUS   = 8'h2f;
  localparam logic [7:0] REG_FSW_CONFIG   = 8'h30;
  localparam logic [7:0] REG_DROP_ASSIST  = 8'h31;
  localparam logic [7:0] REG_DROOP        = 8'h39;
  localparam logic [7:0] REG_LATCH_A      = 8'h46;
  localparam logic [7:0] REG_LATCH_B      = 8'h47;
  localparam logic [7:0] REG_FLOOR        = 8'h4e;
  localparam logic [7:0] REG_UV_CONFIG    = 8'h50;

  // Reset values.
  localparam logic [7:0] RST_FAULT_MASK  = 8'h00;
  localparam logic [4:0] RST_INT_LIMIT   = 5'h00;
  localparam logic [7:0] RST_FSW         = 8'h00;
  localparam logic [7:0] RST_DROP_ASSIST = 8'h01;
  localparam logic [1:0] RST_DROOP       = 2'h3;
  localparam logic [7:0] RST_LATCH       = 8'h00;
  localparam logic [7:0] RST_FLOOR       = 8'h00;
  localparam logic [7:0] RST_UV_CONFIG   = 8'h00;

  // Field positions.
  localparam int unsigned BIT_TEMP_MASK   = 0;
  localparam int unsigned BIT_ASSIST_EN   = 0;
  localparam int unsigned BIT_LIMIT_SRC   = 0;
  localparam int unsigned BIT_FLOOR_EN    = 7;
  localparam int unsigned BIT_UV_DISABLE  = 0;
  localparam int unsigned LIMIT_W         = 5;
  localparam int unsigned FLOOR_W         = 5;

  // Droop coefficient codes; code 3 gives no droop.
  localparam logic [1:0] DROOP_25  = 2'h0;
  localparam logic [1:0] DROOP_50  = 2'h1;
  localparam logic [1:0] DROOP_100 = 2'h2;
  localparam logic [1:0] DROOP_0   = 2'h3;

  // Zones in which only one phase runs.
  localparam logic [2:0] ZONE_3 = 3'h3;
  localparam logic [2:0] ZONE_4 = 3'h4;

  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned WINDOW_MS     = 2;
  localparam int unsigned WIN_CYC       = (WINDOW_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned WIN_W         = 16;

  // Serial slave address; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR = 7'h2a;

  typedef enum logic [2:0] {
    BFL_IDLE  = 3'b000,
    BFL_ADDR  = 3'b001,
    BFL_PTR   = 3'b011,
    BFL_WDATA = 3'b010,
    BFL_ACKO  = 3'b110,
    BFL_RDATA = 3'b111,
    BFL_ACKI  = 3'b101
  } bfl_i2c_e;

  // Comparator and converter levels arriving from the analog front end.
  typedef struct packed {
    logic       stage_temp_high;
    logic       out_below_uv;
    logic       out_below_floor;
    logic       floor_above_uv;
    logic       current_sum_low;
    logic       limit_event;
    logic       enable_pin;
    logic [7:0] pin_limit_code;
  } bfl_cmp_s;

endpackage

`default_nettype wire

/* rtl/bfl_win_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module bfl_win_timer #(
  parameter int unsigned CW = 16
) (
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  input  wire logic          ce,
  input  wire logic [CW-1:0] len,
  input  wire logic          trig,
  output logic               active
);

  logic [CW-1:0] cnt_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r  <= '0;
      active <= 1'b0;
    end else if (ce) begin
      if (trig) begin
        cnt_r  <= len - 1'b1;
        active <= 1'b1;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end else begin
        active <= 1'b0;
      end
    end
  end

endmodule // bfl_win_timer

`default_nettype wire

/* rtl/bfl_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none

module bfl_supervisor #(
  parameter int unsigned WIN_CYC  = bfl_pkg::WIN_CYC,
  parameter logic [6:0]  DEV_ADDR = bfl_pkg::DEV_ADDR
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  input  wire logic                       ce,
  input  wire logic                       scl_i,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe,
  input  wire bfl_pkg::bfl_cmp_s          cmp_i,
  input  wire logic [2:0]                 zone,
  input  wire logic                       fast_drop,
  output logic                            all_phases_on,
  output logic                            ocl_bypass,
  output logic [7:0]                      phase_limit,
  output logic                            limit_from_reg,
  output logic                            phases_mid,
  output logic                            out_enable,
  output logic [1:0]                      droop_coef,
  output logic [7:0]                      fsw_setting,
  output logic                            fsw_load,
  output logic [bfl_pkg::FLOOR_W-1:0]     floor_level
);
  import bfl_pkg::*;

  bfl_cmp_s cmp_q1, cmp_s;
  logic [2:0] scl_q, sda_q;
  logic en_prev_r;

  // Two flip-flops on every comparator and serial pin (zone and fast_drop are not synchronised); the third stage only serves edge detection.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmp_q1    <= '0;
      cmp_s     <= '0;
      scl_q     <= 3'h7;
      sda_q     <= 3'h7;
      en_prev_r <= 1'b0;
    end else if (ce) begin
      cmp_q1    <= cmp_i;
      cmp_s     <= cmp_q1;
      scl_q     <= {scl_q[1:0], scl_i};
      sda_q     <= {sda_q[1:0], sda_i};
      en_prev_r <= cmp_s.enable_pin;
    end
  end

  wire scl_s    = scl_q[1];
  wire sda_s    = sda_q[1];
  wire scl_rise = scl_s & ~scl_q[2];
  wire scl_fall = ~scl_s & scl_q[2];
  wire i2c_start = scl_s & scl_q[2] & sda_q[2] & ~sda_s;
  wire i2c_stop  = scl_s & scl_q[2] & ~sda_q[2] & sda_s;
  wire en_fall   = en_prev_r & ~cmp_s.enable_pin;

  // Register storage.
  logic [7:0] mask_r, pin_lim_r, fsw_r, assist_r, latch_a_r, latch_b_r, floor_r, uvcfg_r;
  logic [LIMIT_W-1:0] int_lim_r;
  logic [1:0] droop_r;
  logic temp_f_r, uv_f_r, ocp_f_r;

  bfl_i2c_e st_r, after_r;
  logic [3:0] bcnt_r;
  logic [7:0] sh_r, tx_r, ptr_r, wr_addr_r, wr_data_r;
  logic nack_r, wr_r;

  function automatic logic [7:0] rd_fn(input logic [7:0] a);
    case (a)
      REG_FAULT_MASK:   rd_fn = mask_r;
      REG_FAULT_STATUS: rd_fn = {5'h00, ocp_f_r, uv_f_r, temp_f_r};
      REG_PIN_LIMIT:    rd_fn = pin_lim_r;
      REG_INT_LIMIT:    rd_fn = {3'h0, int_lim_r};
      REG_FSW_STATUS:   rd_fn = fsw_r;
      REG_FSW_CONFIG:   rd_fn = fsw_r;
      REG_DROP_ASSIST:  rd_fn = assist_r;
      REG_DROOP:        rd_fn = {6'h00, droop_r};
      REG_LATCH_A:      rd_fn = latch_a_r;
      REG_LATCH_B:      rd_fn = latch_b_r;
      REG_FLOOR:        rd_fn = floor_r;
      REG_UV_CONFIG:    rd_fn = uvcfg_r;
      default:          rd_fn = 8'h00;
    endcase
  endfunction

  wire [7:0] rd_now  = rd_fn(ptr_r);
  wire [7:0] rd_next = rd_fn(ptr_r + 8'h01);

  // Serial slave: samples on clock rise, drives and advances on clock fall.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r      <= BFL_IDLE;
      after_r   <= BFL_IDLE;
      bcnt_r    <= 4'h0;
      sh_r      <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= 8'h00;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      nack_r    <= 1'b0;
      wr_r      <= 1'b0;
      sda_oe    <= 1'b0;
      sda_o     <= 1'b0;
    end else if (ce) begin
      wr_r <= 1'b0;
      if (i2c_start) begin
        st_r   <= BFL_ADDR;
        bcnt_r <= 4'h0;
        sda_oe <= 1'b0;
      end else if (i2c_stop) begin
        st_r   <= BFL_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (st_r == BFL_ADDR || st_r == BFL_PTR || st_r == BFL_WDATA) begin
          sh_r   <= {sh_r[6:0], sda_s};
          bcnt_r <= bcnt_r + 4'h1;
        end
        if (st_r == BFL_ACKI) begin
          nack_r <= sda_s;
        end
      end else if (scl_fall) begin
        case (st_r)
          BFL_IDLE: begin
            sda_oe <= 1'b0;
          end
          BFL_ADDR: begin
            if (bcnt_r == 4'h8) begin
              if (sh_r[7:1] == DEV_ADDR) begin
                st_r    <= BFL_ACKO;
                sda_oe  <= 1'b1;
                after_r <= sh_r[0] ? BFL_RDATA : BFL_PTR;
              end else begin
                st_r <= BFL_IDLE;
              end
            end
          end
          BFL_PTR: begin
            if (bcnt_r == 4'h8) begin
              ptr_r   <= sh_r;
              st_r    <= BFL_ACKO;
              sda_oe  <= 1'b1;
              after_r <= BFL_WDATA;
            end
          end
          BFL_WDATA: begin
            if (bcnt_r == 4'h8) begin
              wr_r      <= 1'b1;
              wr_addr_r <= ptr_r;
              wr_data_r <= sh_r;
              ptr_r     <= ptr_r + 8'h01;
              st_r      <= BFL_ACKO;
              sda_oe    <= 1'b1;
              after_r   <= BFL_WDATA;
            end
          end
          BFL_ACKO: begin
            st_r <= after_r;
            if (after_r == BFL_RDATA) begin
              sda_oe <= ~rd_now[7];
              tx_r   <= {rd_now[6:0], 1'b0};
              bcnt_r <= 4'h1;
            end else begin
              sda_oe <= 1'b0;
              bcnt_r <= 4'h0;
            end
          end
          BFL_RDATA: begin
            if (bcnt_r == 4'h8) begin
              sda_oe <= 1'b0;
              st_r   <= BFL_ACKI;
            end else begin
              sda_oe <= ~tx_r[7];
              tx_r   <= {tx_r[6:0], 1'b0};
              bcnt_r <= bcnt_r + 4'h1;
            end
          end
          BFL_ACKI: begin
            if (nack_r) begin
              st_r <= BFL_IDLE;
            end else begin
              ptr_r  <= ptr_r + 8'h01;
              sda_oe <= ~rd_next[7];
              tx_r   <= {rd_next[6:0], 1'b0};
              bcnt_r <= 4'h1;
              st_r   <= BFL_RDATA;
            end
          end
          default: begin
            st_r <= BFL_IDLE;
          end
        endcase
      end
    end
  end

  // Host-written registers.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mask_r    <= RST_FAULT_MASK;
      int_lim_r <= RST_INT_LIMIT;
      fsw_r     <= RST_FSW;
      fsw_load  <= 1'b0;
      assist_r  <= RST_DROP_ASSIST;
      droop_r   <= RST_DROOP;
      latch_a_r <= RST_LATCH;
      latch_b_r <= RST_LATCH;
      floor_r   <= RST_FLOOR;
      uvcfg_r   <= RST_UV_CONFIG;
    end else if (ce) begin
      fsw_load <= wr_r && wr_addr_r == REG_FSW_CONFIG;
      if (wr_r) begin
        case (wr_addr_r)
          REG_FAULT_MASK:  mask_r    <= wr_data_r;
          REG_INT_LIMIT:   int_lim_r <= wr_data_r[LIMIT_W-1:0];
          REG_FSW_CONFIG:  fsw_r     <= wr_data_r;
          REG_DROP_ASSIST: assist_r  <= wr_data_r;
          REG_DROOP:       droop_r   <= wr_data_r[1:0];
          REG_LATCH_A:     latch_a_r <= wr_data_r;
          REG_LATCH_B:     latch_b_r <= wr_data_r;
          REG_FLOOR:       floor_r   <= wr_data_r;
          REG_UV_CONFIG:   uvcfg_r   <= wr_data_r;
          default:         fsw_r     <= fsw_r;
        endcase
      end
    end
  end

  // Fault latches: a temperature or undervoltage fault present in the enable-falling cycle still sets; overcurrent needs the enable pin high.
  wire temp_set = cmp_s.stage_temp_high & ~mask_r[BIT_TEMP_MASK];
  wire uv_set   = cmp_s.out_below_uv & ~uvcfg_r[BIT_UV_DISABLE] & out_enable;
  wire ocp_set  = cmp_s.current_sum_low & cmp_s.enable_pin;
  logic temp_nxt, uv_nxt, ocp_nxt;
  always_comb begin
    temp_nxt = temp_set | (temp_f_r & ~en_fall);
    uv_nxt   = uv_set | (uv_f_r & ~en_fall);
    ocp_nxt  = ocp_set | (ocp_f_r & ~en_fall);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      temp_f_r   <= 1'b0;
      uv_f_r     <= 1'b0;
      ocp_f_r    <= 1'b0;
      out_enable <= 1'b0;
      phases_mid <= 1'b0;
    end else if (ce) begin
      temp_f_r   <= temp_nxt;
      uv_f_r     <= uv_nxt;
      ocp_f_r    <= ocp_nxt;
      out_enable <= cmp_s.enable_pin & ~(temp_nxt | uv_nxt | ocp_nxt);
      phases_mid <= ocp_nxt;
    end
  end

  // pin level sampled on the fly
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_lim_r      <= 8'h00;
      phase_limit    <= 8'h00;
      limit_from_reg <= 1'b0;
    end else if (ce) begin
      pin_lim_r      <= cmp_s.pin_limit_code;
      limit_from_reg <= latch_a_r[BIT_LIMIT_SRC];
      phase_limit    <= latch_a_r[BIT_LIMIT_SRC] ? {3'h0, int_lim_r} : pin_lim_r;
    end
  end

  assign droop_coef  = droop_r;
  assign fsw_setting = fsw_r;
  assign floor_level = floor_r[FLOOR_W-1:0];

  wire assist_trig = assist_r[BIT_ASSIST_EN] & fast_drop & (zone == ZONE_3 || zone == ZONE_4);
  wire bypass_trig = floor_r[BIT_FLOOR_EN] & cmp_s.limit_event & cmp_s.out_below_floor &
                     (uvcfg_r[BIT_UV_DISABLE] | cmp_s.floor_above_uv);

  bfl_win_timer #(.CW(WIN_W)) u_assist (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ce      (ce),
    .len     (WIN_W'(WIN_CYC)),
    .trig    (assist_trig),
    .active  (all_phases_on)
  );

  bfl_win_timer #(.CW(WIN_W)) u_bypass (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ce      (ce),
    .len     (WIN_W'(WIN_CYC)),
    .trig    (bypass_trig),
    .active  (ocl_bypass)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  assist_window_a: assert property (ce && assist_trig |=> all_phases_on)
    else $error("Assist trigger did not force all phases on.");
  fsw_apply_a: assert property (ce && wr_r && wr_addr_r == REG_FSW_CONFIG |=>
      fsw_load && fsw_setting == $past(wr_data_r))
    else $error("Frequency write not applied.");
  droop_hold_a: assert property (ce && !(wr_r && wr_addr_r == REG_DROOP) |=> $stable(droop_coef))
    else $error("Droop changed without a write.");
  limit_select_a: assert property (ce && $past(ce) |-> phase_limit ==
      ($past(latch_a_r[BIT_LIMIT_SRC]) ? {3'h0, $past(int_lim_r)} : $past(pin_lim_r)))
    else $error("Phase limit source wrong.");
  temp_mask_a: assert property (ce && mask_r[BIT_TEMP_MASK] && !temp_f_r |=> !temp_f_r)
    else $error("Masked stage fault latched.");
  latch_hold_a: assert property (ce && (temp_f_r || uv_f_r || ocp_f_r) && !en_fall
      |=> !out_enable)
    else $error("Output enabled while latched.");
  ocp_mid_a: assert property (ce && ocp_set |=> phases_mid && !out_enable && ocp_f_r)
    else $error("Overcurrent did not latch mid level.");
  bypass_win_a: assert property (ce && bypass_trig |=> ocl_bypass)
    else $error("Bypass window not opened.");
  uv_latch_a: assert property (ce && uv_set |=> uv_f_r && !out_enable)
    else $error("Undervoltage did not latch.");

endmodule // bfl_supervisor

`default_nettype wire

/* tb/bfl_host.sv */
`timescale 1ns/1ps
`default_nettype none

module bfl_host (
  input  wire logic ref_clk,
  input  wire logic sda_pad,
  output logic      scl,
  output logic      sda_low
);
  import bfl_pkg::*;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Six clocks a level keeps well clear of the three the slave synchroniser needs.
  task automatic hp();
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  // Sending a one releases the line, so the same bit slot also reads.
  task automatic clk_bit(input logic b, output logic s);
    sda_low = !b;
    hp();
    scl = 1'b1;
    hp();
    s = sda_pad;
    scl = 1'b0;
    hp();
  endtask

  task automatic start();
    if (!scl) begin
      sda_low = 1'b0;
      hp();
      scl = 1'b1;
      hp();
    end
    sda_low = 1'b1;
    hp();
    scl = 1'b0;
    hp();
  endtask

  task automatic stop();
    sda_low = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b0;
    hp();
  endtask

  task automatic tx(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(v[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k1, k2, k3;
    start();
    tx({DEV_ADDR, 1'b0}, k1);
    tx(a, k2);
    tx(d, k3);
    stop();
    ok = k1 && k2 && k3;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k1, k2, k3, s;
    start();
    tx({DEV_ADDR, 1'b0}, k1);
    tx(a, k2);
    start();
    tx({DEV_ADDR, 1'b1}, k3);
    for (int i = 0; i < 8; i++) begin
      clk_bit(1'b1, s);
      d = {d[6:0], s};
    end
    clk_bit(1'b1, s);
    stop();
    ok = k1 && k2 && k3;
  endtask
endmodule // bfl_host

`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  import bfl_pkg::*;

  localparam int unsigned WIN = 20;

  logic                ref_clk;
  logic                rstn;
  logic                scl;
  logic                sda_low;
  logic                sda_o;
  logic                sda_oe;
  bfl_cmp_s            cmp;
  logic [2:0]          zone;
  logic                fast_drop;
  logic                all_phases_on;
  logic                ocl_bypass;
  logic [7:0]          phase_limit;
  logic                limit_from_reg;
  logic                phases_mid;
  logic                out_enable;
  logic [1:0]          droop_coef;
  logic [7:0]          fsw_setting;
  logic [FLOOR_W-1:0]  floor_level;
  logic [7:0]          mreg [int];
  logic [7:0]          ra [9] = '{8'h22, 8'h2e, 8'h30, 8'h31, 8'h39, 8'h46, 8'h47, 8'h4e, 8'h50};
  int                  fb [3] = '{14, 13, 10};
  logic                ce;
  logic                fsw_load;
  logic [7:0]          fst;
  int                  loads;
  int                  error_cnt;
  int                  checked;
  logic [7:0]          v;
  wire logic           sda_pad = !(sda_low || (sda_oe && !sda_o));

  bfl_supervisor #(.WIN_CYC(WIN)) i_bfl_supervisor (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .scl_i(scl), .sda_i(sda_pad),
    .sda_o(sda_o), .sda_oe(sda_oe), .cmp_i(cmp), .zone(zone), .fast_drop(fast_drop),
    .all_phases_on(all_phases_on), .ocl_bypass(ocl_bypass), .phase_limit(phase_limit),
    .limit_from_reg(limit_from_reg), .phases_mid(phases_mid), .out_enable(out_enable),
    .droop_coef(droop_coef), .fsw_setting(fsw_setting), .fsw_load(fsw_load),
    .floor_level(floor_level)
  );

  bfl_host i_bfl_host (.ref_clk(ref_clk), .sda_pad(sda_pad), .scl(scl), .sda_low(sda_low));

  always #25 ref_clk = !ref_clk;

  // Counts every cycle in which the frequency load strobe stands.
  always @(posedge ref_clk) begin
    if (fsw_load === 1'b1) loads++;
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wt(ref logic s, input logic b);
    for (int i = 0; i < 60 && s !== b; i++) step(1);
    if (s !== b) begin
      error_cnt++;
      $display("BAD wait expected %b seen %b", b, s);
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    i_bfl_host.wr(a, d, ok);
    if (mreg.exists(a)) begin
      mreg[a] = d;
      chk("ack", 8'h1, {7'h0, ok});
    end
  endtask

  function automatic logic [7:0] rexp(input logic [7:0] a);
    if (a == REG_PIN_LIMIT) return cmp.pin_limit_code;
    if (a == REG_FSW_STATUS) return mreg[REG_FSW_CONFIG];
    if (a == REG_FAULT_STATUS) return fst;
    return mreg.exists(a) ? mreg[a] : 8'h00;
  endfunction

  task automatic rd(input logic [7:0] a);
    logic ok;
    logic [7:0] d;
    i_bfl_host.rd(a, d, ok);
    chk("ack", 8'h1, {7'h0, ok});
    chk($sformatf("reg %h", a), rexp(a), d);
  endtask

  task automatic trg(input int t, input logic b);
    if (t == 0) fast_drop = b;
    else cmp.limit_event = b;
  endtask

  // Total high cycles of a window, retriggered after gap cycles when gap is positive.
  task automatic win(input int t, input int gap, input logic [7:0] e);
    int n;
    n = 0;
    for (int i = 0; i < 60; i++) begin
      if (i == 0 || i == gap) trg(t, 1'b1);
      if (i == 1 || i == gap + 1) trg(t, 1'b0);
      // A negative gap freezes the block for five edges inside the window.
      ce = !(gap < 0 && i >= 4 && i < 9);
      if ((t == 0 ? all_phases_on : ocl_bypass) === 1'b1) n++;
      step(1);
    end
    chk(t == 0 ? "assist window" : "bypass window", e, 8'(n));
  endtask

  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    cmp = '0;
    cmp.enable_pin = 1'b1;
    ce = 1'b1;
    fst = 8'h00;
    zone = 3'h0;
    fast_drop = 1'b0;
    error_cnt = 0;
    checked = 0;
    foreach (ra[i]) mreg[ra[i]] = 8'h00;
    mreg[REG_DROP_ASSIST] = RST_DROP_ASSIST;
    mreg[REG_DROOP] = {6'h0, RST_DROOP};
    void'($urandom(7));
    repeat (2) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    step(2);
    chk("droop", {6'h0, DROOP_0}, {6'h0, droop_coef});
    chk("bypass", 8'h0, {7'h0, ocl_bypass});
    chk("assist", 8'h0, {7'h0, all_phases_on});
    wt(out_enable, 1'b1);
    foreach (ra[i]) rd(ra[i]);
    rd(8'h60);
    $display("reset test done");
    v = 8'($urandom);
    wr(REG_FSW_CONFIG, v);
    step(4);
    chk("fsw", v, fsw_setting);
    chk("fsw load", 8'h1, 8'(loads));
    rd(REG_FSW_STATUS);
    for (int c = 0; c < 4; c++) begin
      wr(REG_DROOP, 8'(c));
      step(4);
      chk("droop", 8'(c), {6'h0, droop_coef});
      rd(REG_DROOP);
    end
    $display("frequency and droop test done");
    cmp.pin_limit_code = 8'($urandom);
    step(6);
    rd(REG_PIN_LIMIT);
    chk("limit", cmp.pin_limit_code, phase_limit);
    chk("source", 8'h0, {7'h0, limit_from_reg});
    wr(REG_PIN_LIMIT, ~cmp.pin_limit_code);
    rd(REG_PIN_LIMIT);
    v = {3'h0, 5'($urandom)};
    wr(REG_INT_LIMIT, v);
    wr(REG_LATCH_A, 8'h01);
    step(4);
    chk("source", 8'h1, {7'h0, limit_from_reg});
    chk("limit", v, phase_limit);
    rd(REG_INT_LIMIT);
    wr(REG_LATCH_A, 8'h00);
    wr(REG_LATCH_B, 8'($urandom));
    rd(REG_LATCH_B);
    $display("limit source test done");
    for (int z = 0; z < 5; z++) begin
      zone = 3'(z);
      win(0, 0, (z >= 3) ? 8'(WIN) : 8'h0);
    end
    win(0, 8, 8'(WIN + 8));
    win(0, -5, 8'(WIN + 5));
    wr(REG_DROP_ASSIST, 8'h00);
    win(0, 0, 8'h0);
    $display("assist test done");
    wr(REG_FAULT_MASK, 8'h01);
    cmp.stage_temp_high = 1'b1;
    step(8);
    chk("masked", 8'h1, {7'h0, out_enable});
    cmp.stage_temp_high = 1'b0;
    wr(REG_FAULT_MASK, 8'h00);
    for (int f = 0; f < 3; f++) begin
      cmp[fb[f]] = 1'b1;
      wt(out_enable, 1'b0);
      chk("mid", {7'h0, f == 2}, {7'h0, phases_mid});
      cmp[fb[f]] = 1'b0;
      step(6);
      chk("held", 8'h0, {7'h0, out_enable});
      fst = 8'(1 << f);
      rd(REG_FAULT_STATUS);
      cmp.enable_pin = 1'b0;
      step(4);
      cmp.enable_pin = 1'b1;
      fst = 8'h00;
      wt(out_enable, 1'b1);
      rd(REG_FAULT_STATUS);
      chk("mid", 8'h0, {7'h0, phases_mid});
    end
    $display("fault test done");
    for (int c = 0; c < 4; c++) begin
      v = {c < 3, 2'h0, 5'($urandom)};
      wr(REG_FLOOR, v);
      wr(REG_UV_CONFIG, {7'h0, c == 1});
      step(4);
      chk("floor", {3'h0, v[4:0]}, {3'h0, floor_level});
      cmp.out_below_floor = 1'b1;
      cmp.floor_above_uv = (c == 0);
      win(1, 0, (c < 2) ? 8'(WIN) : 8'h0);
      cmp.out_below_floor = 1'b0;
    end
    $display("bypass test done");
    give_verdict();
  end
endmodule // tb

`default_nettype wire
